/* File: hw/smc_pkg.sv */
package smc_pkg;
    // timing, figures in their own units
    localparam int unsigned CLK_KHZ      = 100000;
    localparam int unsigned STORE_WIN_MS = 5000;
    localparam int unsigned HOLD_MS      = 1500;
    localparam int unsigned BEEP_MS      = 100;
    localparam int unsigned STORE_CYC    = STORE_WIN_MS * CLK_KHZ;
    localparam int unsigned HOLD_CYC     = HOLD_MS * CLK_KHZ;
    localparam int unsigned BEEP_CYC     = BEEP_MS * CLK_KHZ;
    // arrival flags are ignored this long after a new target
    localparam logic [31:0] SETTLE_CYC   = 32'h4;

    localparam int unsigned NSLOT  = 3;
    localparam int unsigned POS_W  = 8;

    // register map, byte addresses
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_SLOT0    = 8'h10;
    localparam logic [7:0] OFS_STEP     = 8'h04;

    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_MT_BIT = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h1;

    localparam int unsigned IRQ_W          = 5;
    localparam int unsigned IRQ_STORE_DONE = 0;
    localparam int unsigned IRQ_STORE_END  = 1;
    localparam int unsigned IRQ_RC_DONE    = 2;
    localparam int unsigned IRQ_RC_ERR     = 3;
    localparam int unsigned IRQ_RC_CANCEL  = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

    typedef enum logic [3:0] {
        SMC_IDLE   = 4'b0001,
        SMC_STORE  = 4'b0010,
        SMC_HOLD   = 4'b0100,
        SMC_RECALL = 4'b1000
    } smc_state_t;

    typedef struct packed {
        logic [POS_W-1:0] seat;
        logic [POS_W-1:0] mirror_h;
        logic [POS_W-1:0] mirror_v;
    } smc_pos_t;

    typedef struct packed {
        logic       set_btn;
        logic       stop_btn;
        logic [2:0] pos_btn;
        logic       ign_on;
        logic       gear_park;
        logic       park_brake;
        logic       speed_over;
        logic       manual_adj;
        logic       sensor_err;
        logic [2:0] arrived;
    } smc_vin_t;
endpackage

/* File: hw/smc_seat_memory_unit.sv */
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
// Overview of operation
// - arming opens 5 s window; button saves slot
// - three independent slots of seat and mirrors
// - no button in 5 s ends store
// - ignition off, halt or save ends store
// - refuse recall over 3 km/h or unsafe gear
// - manual gearbox: brake released refuses recall
// - slots may be rewritten without limit
// - arming indicator lit while store is open
// - one beep when store mode opens
// - two beeps on store or recall done
// - three beeps on sensor error in recall
// - position button recalls slot with ignition on
// - other button during recall retargets recall
// - one beep when a recall is accepted
// - halt button or ignition off stops recall
// - manual seat or mirror move cancels recall
module smc_seat_memory_unit
    import smc_pkg::*;
#(
    parameter int unsigned STORE_CYCLES = STORE_CYC,
    parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
    parameter int unsigned BEEP_CYCLES  = BEEP_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire smc_vin_t    vin,
    input  wire smc_pos_t    cur_pos,
    output smc_pos_t         target_pos,
    output logic             move_req,
    output logic             set_led,
    output logic             buzzer,
    output logic             irq
);

    if (STORE_CYCLES < 1 || HOLD_CYCLES < 1 || BEEP_CYCLES < 1) begin : g_chk
        $error("timing counts must be at least one cycle");
    end

    function automatic logic [1:0] first_btn(input logic [2:0] b);
        first_btn = b[0] ? 2'h0 : (b[1] ? 2'h1 : 2'h2);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, all vehicle and position pins pass two flops
    localparam int unsigned SW = $bits(smc_vin_t) + $bits(smc_pos_t);
    logic [SW-1:0] s1_reg;
    logic [SW-1:0] s2_reg;
    smc_vin_t      vin_s;
    smc_vin_t      vin_p_reg;
    smc_pos_t      cur_pos_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            vin_p_reg <= '0;
        end else begin
            s1_reg    <= {vin, cur_pos};
            s2_reg    <= s1_reg;
            vin_p_reg <= vin_s;
        end
    end
    assign {vin_s, cur_pos_s} = s2_reg;

    logic       set_rise;
    logic [2:0] pos_rise;
    assign set_rise = vin_s.set_btn & ~vin_p_reg.set_btn;
    assign pos_rise = vin_s.pos_btn & ~vin_p_reg.pos_btn;

    ////////////////////////////////////////////////////////////////////////
    // control state
    smc_state_t       st_reg;
    smc_state_t       st_next;
    logic [1:0]       sel_reg;
    logic [1:0]       sel_next;
    logic [31:0]      tmr_reg;
    logic             tmr_clr;
    logic             save;
    logic             retarget;
    logic [1:0]       beep_req;
    logic [IRQ_W-1:0] ev;
    logic [1:0]       ctrl_reg;
    smc_pos_t         slot_mem [NSLOT];
    logic             recall_ok;
    logic             abort_rc;
    logic [2:0]       other_rise;
    logic             ign;
    logic             mt;

    assign ign = vin_s.ign_on;
    assign mt  = ctrl_reg[CTRL_MT_BIT];
    // manual gearbox needs the brake; automatic needs park or brake
    assign recall_ok = ign & ~vin_s.speed_over &
                       (mt ? vin_s.park_brake
                           : (vin_s.gear_park | vin_s.park_brake));
    assign abort_rc   = ~recall_ok | vin_s.stop_btn | vin_s.manual_adj;
    assign other_rise = pos_rise & ~(3'h1 << sel_reg);

    always_comb begin
        st_next  = st_reg;
        sel_next = sel_reg;
        tmr_clr  = 1'b0;
        save     = 1'b0;
        retarget = 1'b0;
        beep_req = 2'h0;
        ev       = '0;
        case (st_reg)
            SMC_IDLE: begin
                if (ctrl_reg[CTRL_EN_BIT] && ign && set_rise) begin
                    st_next  = SMC_STORE;
                    beep_req = 2'h1;
                end else if (ctrl_reg[CTRL_EN_BIT] && |pos_rise && recall_ok) begin
                    st_next  = SMC_HOLD;
                    sel_next = first_btn(pos_rise);
                end
            end
            SMC_STORE: begin
                if (!ign || vin_s.stop_btn) begin
                    st_next           = SMC_IDLE;
                    ev[IRQ_STORE_END] = 1'b1;
                end else if (|pos_rise) begin
                    save               = 1'b1;
                    st_next            = SMC_IDLE;
                    beep_req           = 2'h2;
                    ev[IRQ_STORE_DONE] = 1'b1;
                end else if (tmr_reg >= STORE_CYCLES - 1) begin
                    st_next           = SMC_IDLE;
                    ev[IRQ_STORE_END] = 1'b1;
                end
            end
            SMC_HOLD: begin
                // a short tap is dropped silently: the hold is the accept
                if (!vin_s.pos_btn[sel_reg] || abort_rc) begin
                    st_next = SMC_IDLE;
                end else if (tmr_reg >= HOLD_CYCLES - 1) begin
                    st_next  = SMC_RECALL;
                    retarget = 1'b1;
                    beep_req = 2'h1;
                end
            end
            SMC_RECALL: begin
                if (abort_rc) begin
                    st_next           = SMC_IDLE;
                    ev[IRQ_RC_CANCEL] = 1'b1;
                end else if (vin_s.sensor_err) begin
                    st_next        = SMC_IDLE;
                    beep_req       = 2'h3;
                    ev[IRQ_RC_ERR] = 1'b1;
                end else if (|other_rise) begin
                    sel_next = first_btn(other_rise);
                    retarget = 1'b1;
                    tmr_clr  = 1'b1;
                    beep_req = 2'h1;
                end else if (&vin_s.arrived && tmr_reg >= SETTLE_CYC) begin
                    st_next         = SMC_IDLE;
                    beep_req        = 2'h2;
                    ev[IRQ_RC_DONE] = 1'b1;
                end
            end
            default: st_next = SMC_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg  <= SMC_IDLE;
            sel_reg <= 2'h0;
            tmr_reg <= 32'h0;
        end else begin
            st_reg  <= st_next;
            sel_reg <= sel_next;
            if (tmr_clr || st_next != st_reg || st_reg == SMC_IDLE) begin
                tmr_reg <= 32'h0;
            end else begin
                tmr_reg <= tmr_reg + 32'h1;
            end
        end
    end

    // slot storage; reset erases, as losing supply does
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < NSLOT; k++) begin
                slot_mem[k] <= '0;
            end
        end else if (save) begin
            slot_mem[first_btn(pos_rise)] <= cur_pos_s;
        end
    end

    // actuator side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_pos <= '0;
            move_req   <= 1'b0;
            set_led    <= 1'b0;
        end else begin
            if (retarget) begin
                target_pos <= slot_mem[sel_next];
            end
            move_req <= (st_next == SMC_RECALL);
            set_led  <= (st_next == SMC_STORE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buzzer: equal on and off phases; a new request restarts the pattern
    logic [1:0]  beep_rem_reg;
    logic [31:0] bcnt_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            beep_rem_reg <= 2'h0;
            bcnt_reg     <= 32'h0;
            buzzer       <= 1'b0;
        end else if (beep_req != 2'h0) begin
            beep_rem_reg <= beep_req;
            bcnt_reg     <= 32'h0;
            buzzer       <= 1'b1;
        end else if (beep_rem_reg != 2'h0) begin
            if (bcnt_reg >= BEEP_CYCLES - 1) begin
                bcnt_reg <= 32'h0;
                buzzer   <= ~buzzer;
                if (buzzer) begin
                    beep_rem_reg <= beep_rem_reg - 2'h1;
                end
            end else begin
                bcnt_reg <= bcnt_reg + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states
    logic             dp_wr_reg;
    logic [7:0]       dp_addr_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] w1c;
    logic [31:0]      rd_mux;
    logic             acc;

    assign acc = hsel & htrans[1] & hready;
    assign w1c = (dp_wr_reg && dp_addr_reg == OFS_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0;

    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            OFS_CTRL:     rd_mux = {30'h0, ctrl_reg};
            OFS_STATUS:   rd_mux = {23'h0, buzzer, move_req, set_led, sel_reg, st_reg};
            OFS_IRQ_STAT: rd_mux = {27'h0, irq_stat_reg};
            OFS_IRQ_MASK: rd_mux = {27'h0, irq_mask_reg};
            default:      rd_mux = 32'h0;
        endcase
        for (int k = 0; k < NSLOT; k++) begin
            if (haddr[7:0] == OFS_SLOT0 + 8'(k) * OFS_STEP) begin
                rd_mux = {8'h0, slot_mem[k]};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            dp_wr_reg <= acc & hwrite;
            if (acc) begin
                dp_addr_reg <= haddr[7:0];
            end
            if (acc && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg     <= CTRL_RST;
            irq_mask_reg <= IRQ_MASK_RST;
        end else if (dp_wr_reg) begin
            if (dp_addr_reg == OFS_CTRL) begin
                ctrl_reg <= hwdata[1:0];
            end
            if (dp_addr_reg == OFS_IRQ_MASK) begin
                irq_mask_reg <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // a new event beats a simultaneous clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= '0;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
            irq          <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_STORE_OPEN: assert property (
        (st_reg == SMC_IDLE) && ctrl_reg[CTRL_EN_BIT] && ign && set_rise
        |=> (st_reg == SMC_STORE) && set_led && buzzer && beep_rem_reg == 2'h1)
        else $error("store mode did not open");
    AST_STORE_SAVE: assert property (
        (st_reg == SMC_STORE) && ign && !vin_s.stop_btn && |pos_rise
        |=> slot_mem[$past(first_btn(pos_rise))] == $past(cur_pos_s)
        && (st_reg == SMC_IDLE) && beep_rem_reg == 2'h2)
        else $error("slot not saved");
    AST_STORE_TMO: assert property (
        (st_reg == SMC_STORE) |-> tmr_reg < STORE_CYCLES)
        else $error("store window overran");
    AST_STORE_QUIT: assert property (
        (st_reg == SMC_STORE) && (!ign || vin_s.stop_btn)
        |=> (st_reg == SMC_IDLE) && !set_led)
        else $error("store mode not left");
    AST_REFUSE: assert property (
        (st_reg == SMC_IDLE) && !recall_ok
        |=> st_reg != SMC_HOLD ##1 st_reg != SMC_RECALL)
        else $error("recall started while refused");
    AST_MT_BRAKE: assert property (
        (st_reg == SMC_RECALL) && mt && !vin_s.park_brake
        |=> (st_reg == SMC_IDLE) && !move_req)
        else $error("manual gearbox recall kept");
    AST_CANCEL: assert property (
        (st_reg == SMC_RECALL) && (vin_s.stop_btn || !ign || vin_s.manual_adj)
        |=> (st_reg == SMC_IDLE) && irq_stat_reg[IRQ_RC_CANCEL])
        else $error("recall not stopped");
    AST_HOLD: assert property (
        $rose(st_reg == SMC_RECALL) |-> $past(st_reg == SMC_HOLD)
        && $past(tmr_reg) >= HOLD_CYCLES - 1 && move_req && buzzer)
        else $error("recall began without hold");
    AST_RETARGET: assert property (
        (st_reg == SMC_RECALL) && !abort_rc && !vin_s.sensor_err && |other_rise
        |=> target_pos == slot_mem[sel_reg] && beep_rem_reg == 2'h1 && move_req)
        else $error("recall not retargeted");
    AST_DONE: assert property (
        (st_reg == SMC_RECALL) && !abort_rc && !vin_s.sensor_err
        && !(|other_rise) && &vin_s.arrived && tmr_reg >= SETTLE_CYC
        |=> beep_rem_reg == 2'h2 && !move_req)
        else $error("recall completion missed");
    AST_ERR: assert property (
        (st_reg == SMC_RECALL) && !abort_rc && vin_s.sensor_err
        |=> beep_rem_reg == 2'h3 ##1 buzzer)
        else $error("sensor error not signalled");
    AST_IRQ: assert property (
        irq == $past(|(irq_stat_reg & irq_mask_reg)))
        else $error("interrupt level wrong");

    COV_STORE: cover property ((st_reg == SMC_STORE) ##1 irq_stat_reg[IRQ_STORE_DONE]);
    COV_STORE_TMO: cover property ((st_reg == SMC_STORE) ##1 irq_stat_reg[IRQ_STORE_END]);
    COV_RECALL: cover property ((st_reg == SMC_RECALL) ##1 irq_stat_reg[IRQ_RC_DONE]);
    COV_RETARGET: cover property ((st_reg == SMC_RECALL) && |other_rise);
    COV_ERROR: cover property ((st_reg == SMC_RECALL) ##1 irq_stat_reg[IRQ_RC_ERR]);

endmodule // smc_seat_memory_unit

/* File: tb/smc_actuator.sv */
`timescale 1ns/10ps
module smc_actuator
    import smc_pkg::*;
(
    input  wire logic     hclk,
    input  wire logic     hresetn,
    input  wire smc_pos_t target_pos,
    input  wire logic     move_req,
    input  wire logic     slow,
    input  wire logic     load,
    input  wire smc_pos_t load_pos,
    output smc_pos_t      cur_pos,
    output logic [2:0]    arrived
);
    logic [2:0][7:0] pos_reg;
    logic [2:0][7:0] tgt;
    logic [1:0]      div_reg;

    assign tgt = target_pos;
    assign cur_pos = pos_reg;
    ////////////////////////////////////////
    // slow mode steps once in four cycles, like a loaded seat motor
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_reg <= '0;
            div_reg <= 2'h0;
        end else if (load) begin
            pos_reg <= load_pos;
        end else if (move_req) begin
            div_reg <= div_reg + 2'h1;
            for (int i = 0; i < 3; i++) begin
                if ((!slow || div_reg == 2'h3) && pos_reg[i] != tgt[i])
                    pos_reg[i] <= pos_reg[i] + ((pos_reg[i] < tgt[i]) ? 8'h01 : 8'hff);
            end
        end
    end
    // flags only while commanded, so an old match never reads as done
    always_comb begin
        for (int i = 0; i < 3; i++) arrived[i] = move_req && (pos_reg[i] == tgt[i]);
    end
endmodule // smc_actuator

/* File: tb/seat_position_memory_ctrl_tb.sv */
`timescale 1ns/10ps
module seat_position_memory_ctrl_tb
    import smc_pkg::*;
;
    localparam int unsigned HOLD = 50;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  arr;
    logic        move_req, set_led, buzzer, irq, slow, load, buz_q;
    smc_vin_t    vin, vdrv;
    smc_pos_t    cur_pos, target_pos, load_pos;
    smc_pos_t    exp_slot [3];
    int          failures, check_count, beeps, seed;
    int          rf [3] = '{3, 4, 6};

    smc_seat_memory_unit #(.STORE_CYCLES(200), .HOLD_CYCLES(HOLD), .BEEP_CYCLES(5)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .vin(vin), .cur_pos(cur_pos),
        .target_pos(target_pos), .move_req(move_req), .set_led(set_led),
        .buzzer(buzzer), .irq(irq));
    smc_actuator u_act (
        .hclk(hclk), .hresetn(hresetn), .target_pos(target_pos), .move_req(move_req),
        .slow(slow), .load(load), .load_pos(load_pos), .cur_pos(cur_pos), .arrived(arr));

    assign hready = hreadyout;
    always_comb begin
        vin = vdrv;
        vin.arrived = arr;
    end
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // counts beep starts; cleared off the edge so no race with this block
    always @(posedge hclk) begin
        if (buzzer && !buz_q) beeps++;
        buz_q <= buzzer;
    end
    ////////////////////////////////////////
    task automatic print_verdict;
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 3000) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic clr;
        #1 beeps = 0;
    endtask
    function automatic smc_pos_t rnd;
        logic [31:0] r;
        r = $random(seed);
        return r[23:0];
    endfunction
    // a broken-off recall flags a cancel, the sensor fault flags an error
    function automatic logic [4:0] exp_ev(input int i);
        return (i == 5) ? 5'(1 << IRQ_RC_ERR) : 5'(1 << IRQ_RC_CANCEL);
    endfunction
    // address phase, then data phase; each held until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        repeat (2) begin
            n = 0;
            do @(posedge hclk); while (hready !== 1'b1 && ++n < 3000);
            hang(n);
            htrans <= 2'b00;
            hsel <= 1'b0;
            hwdata <= wd;
        end
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do @(posedge hclk); while (move_req !== 1'b0 && ++n < 3000);
        hang(n);
    endtask
    task automatic irq_chk(input logic [4:0] e, input logic q);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(rd, {27'h0, e});
        chk({31'h0, irq}, {31'h0, q});
        bus(1'b1, OFS_IRQ_STAT, 32'h1f);
    endtask
    task automatic slots_chk;
        for (int k = 0; k < 3; k++) begin
            bus(1'b0, OFS_SLOT0 + OFS_STEP * 8'(k), 32'h0);
            chk(rd, {8'h0, exp_slot[k]});
        end
    endtask
    task automatic place(input smc_pos_t p);
        @(posedge hclk);
        load <= 1'b1;
        load_pos <= p;
        @(posedge hclk);
        load <= 1'b0;
    endtask
    task automatic press_set;
        @(posedge hclk);
        vdrv.set_btn <= 1'b1;
        clr();
        @(posedge hclk);
        vdrv.set_btn <= 1'b0;
    endtask
    // held past the hold time; a short tap would be dropped
    task automatic recall(input int k);
        repeat (4) @(posedge hclk);
        vdrv.pos_btn[k] <= 1'b1;
        clr();
        repeat (HOLD + 10) @(posedge hclk);
        vdrv.pos_btn[k] <= 1'b0;
    endtask
    task automatic cond(input int i, input logic on);
        case (i)
            0: vdrv.manual_adj <= on;
            1: vdrv.stop_btn <= on;
            2: vdrv.ign_on <= !on;
            3: vdrv.speed_over <= on;
            4: vdrv.park_brake <= !on;
            5: vdrv.sensor_err <= on;
            default: {vdrv.gear_park, vdrv.park_brake} <= {!on, !on};
        endcase
    endtask
    task automatic store(input int k);
        smc_pos_t p;
        p = rnd();
        place(p);
        press_set();
        repeat (5) @(posedge hclk);
        chk({31'h0, set_led}, 32'h1);
        repeat (20) @(posedge hclk);
        chk(beeps, 1);
        vdrv.pos_btn[k] <= 1'b1;
        clr();
        @(posedge hclk);
        vdrv.pos_btn[k] <= 1'b0;
        repeat (40) @(posedge hclk);
        chk({31'h0, set_led}, 32'h0);
        chk(beeps, 2);
        exp_slot[k] = p;
        slots_chk();
        irq_chk(5'h01, 1'b1);
    endtask
    ////////////////////////////////////////
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        vdrv = '0;
        vdrv.ign_on = 1'b1;
        vdrv.gear_park = 1'b1;
        vdrv.park_brake = 1'b1;
        {load, slow, hresetn, buz_q} = 4'h0;
        load_pos = '0;
        exp_slot = '{default: '0};
        failures = 0;
        check_count = 0;
        beeps = 0;
        seed = 88757;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, {30'h0, CTRL_RST});
        bus(1'b1, OFS_SLOT0, 32'hffffffff);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        slots_chk();
        bus(1'b1, OFS_IRQ_MASK, 32'h1f);
        for (int k = 0; k < 4; k++) store(k % 3);
        // window runs out, halt, ignition off (last one with irq masked)
        for (int c = 0; c < 3; c++) begin
            if (c == 2) bus(1'b1, OFS_IRQ_MASK, 32'h0);
            press_set();
            repeat (10) @(posedge hclk);
            cond(c, 1'b1);
            repeat ((c == 0) ? 260 : 10) @(posedge hclk);
            cond(c, 1'b0);
            chk({31'h0, set_led}, 32'h0);
            slots_chk();
            irq_chk(5'h02, c != 2);
        end
        bus(1'b1, OFS_IRQ_MASK, 32'h1f);
        place(rnd());
        recall(1);
        chk({31'h0, move_req}, 32'h1);
        chk({8'h0, target_pos}, {8'h0, exp_slot[1]});
        chk(beeps, 1);
        clr();
        wait_idle();
        chk({8'h0, cur_pos}, {8'h0, exp_slot[1]});
        repeat (40) @(posedge hclk);
        chk(beeps, 2);
        irq_chk(5'h04, 1'b1);
        for (int j = 0; j < 3; j++) begin
            bus(1'b1, OFS_CTRL, (j == 1) ? 32'h3 : 32'h1);
            cond(rf[j], 1'b1);
            recall(0);
            chk({31'h0, move_req}, 32'h0);
            chk(beeps, 0);
            cond(rf[j], 1'b0);
        end
        // switched off: neither store nor recall may start
        bus(1'b1, OFS_CTRL, 32'h0);
        press_set();
        recall(0);
        chk({30'h0, set_led, move_req}, 32'h0);
        chk(beeps, 0);
        // slow motors keep the recall running until it is broken off or the sensor fault ends it
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, OFS_CTRL, (i == 4) ? 32'h3 : 32'h1);
            place(exp_slot[2] ^ 24'h808080);
            slow <= 1'b1;
            recall(2);
            chk({31'h0, move_req}, 32'h1);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk(rd, {23'h0, 3'b010, 2'h2, SMC_RECALL});
            cond(i, 1'b1);
            clr();
            repeat (10) @(posedge hclk);
            chk({31'h0, move_req}, 32'h0);
            cond(i, 1'b0);
            repeat (40) @(posedge hclk);
            chk(beeps, (i == 5) ? 3 : 0);
            irq_chk(exp_ev(i), 1'b1);
        end
        bus(1'b1, OFS_CTRL, 32'h1);
        place(exp_slot[0] ^ 24'h808080);
        recall(0);
        vdrv.pos_btn[1] <= 1'b1;
        repeat (2) @(posedge hclk);
        vdrv.pos_btn[1] <= 1'b0;
        repeat (8) @(posedge hclk);
        chk({8'h0, target_pos}, {8'h0, exp_slot[1]});
        slow <= 1'b0;
        wait_idle();
        chk({8'h0, cur_pos}, {8'h0, exp_slot[1]});
        repeat (40) @(posedge hclk);
        irq_chk(5'h04, 1'b1);
        print_verdict();
    end
endmodule // seat_position_memory_ctrl_tb
